// >>> inc/dcc_pkg.sv
package dcc_pkg;

   // Register offsets (byte addresses)
   localparam logic [7:0] CTRL_OFFSET    = 8'h00;
   localparam logic [7:0] SWTRIG_OFFSET  = 8'h04;
   localparam logic [7:0] HOLDR12_OFFSET = 8'h08;
   localparam logic [7:0] HOLDL12_OFFSET = 8'h0c;
   localparam logic [7:0] HOLDR8_OFFSET  = 8'h10;
   localparam logic [7:0] OUTVAL_OFFSET  = 8'h2c;

   // Reset values
   localparam logic [11:0] CTRL_RESET   = 12'h000;
   localparam logic [11:0] HOLD_RESET   = 12'h000;
   localparam logic [11:0] OUTVAL_RESET = 12'h000;
   localparam logic [11:0] LFSR_SEED    = 12'haaa;

   // Control register field positions
   localparam int CHAN_EN_POS  = 0;
   localparam int BUF_OFF_POS  = 1;
   localparam int TRIG_EN_POS  = 2;
   localparam int TRIG_SEL_LSB = 3;
   localparam int TRIG_SEL_MSB = 5;
   localparam int WAVE_LSB     = 6;
   localparam int WAVE_MSB     = 7;
   localparam int WIDTH_LSB    = 8;
   localparam int WIDTH_MSB    = 11;
   localparam int CTRL_BITS    = 12;
   localparam int SWTRIG_POS   = 0;

   // Trigger source codes
   localparam logic [2:0] TSEL_TIMER5  = 3'h0;
   localparam logic [2:0] TSEL_TIMER2  = 3'h1;
   localparam logic [2:0] TSEL_TIMER14 = 3'h3;
   localparam logic [2:0] TSEL_TIMER1  = 3'h4;
   localparam logic [2:0] TSEL_EXTLINE = 3'h6;
   localparam logic [2:0] TSEL_SOFT    = 3'h7;

   // Wave mode codes; any code with bit 1 set is triangle
   localparam logic [1:0] WAVE_NONE = 2'h0;
   localparam logic [1:0] WAVE_LFSR = 2'h1;

   // Width code at or above this selects the full 12 bits
   localparam logic [3:0] WIDTH_FULL = 4'hb;

endpackage

// >>> rtl/dcc_channel.sv
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps

// Function
// R01: Wave added only while trigger enable bit is set.
// R02: Wave mode bits 7:6: 00 none, 01 LFSR, 1x triangle.
// R03: Trigger select bits 5:3 matter only with trigger enabled.
// R04: Select codes map timers 5,2,14,1, external line 9, software; 010/101 reserved.
// R05: Control bit 2 enables the channel trigger.
// R06: Control bit 1 turns the output buffer off.
// R07: Software trigger bit 0 raises a trigger then clears itself.
// R08: Software uses only full word accesses on trigger, holding, output.
// R09: Right 12-bit view loads word bits 11:0.
// R10: Left 12-bit view loads word bits 15:4.
// R11: 8-bit view loads word bits 7:0 as upper eight bits.
// R12: Output register read-only, bits 11:0 show converted value.
// R13: Views share one holding value; 8-bit view zeroes low nibble.
// R14: Copy on selected trigger when enabled, else automatically.
// R15: LFSR mode adds masked low LFSR bits to holding value.
// R16: Triangle mode adds a ramp between 0 and width maximum.
// R17: Control bit 0 enables channel; disabled channel converts nothing.
// R18: Reserved trigger codes produce no trigger events.
module dcc_channel
   import dcc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wrData,
   input  wire logic        wrEn,
   input  wire logic        rdEn,
   output logic      [31:0] rdData,
   input  wire logic        timer5Trig,
   input  wire logic        timer2Trig,
   input  wire logic        timer14Trig,
   input  wire logic        timer1Trig,
   input  wire logic        extLine9,
   output logic      [11:0] convertedValue,
   output logic             convertStrobe,
   output logic             channelEnable,
   output logic             bufferOff
);
   import dcc_pkg::*;

   logic [CTRL_BITS-1:0] ctrl_reg;
   logic                 softTrig_reg;
   logic [11:0]          holding_reg;
   logic [11:0]          lfsr_reg;
   logic [11:0]          tri_reg;
   logic                 triDown_reg;
   logic [4:0]           hwPrev_reg;
   logic [31:0]          rdData_reg;
   logic [11:0]          outVal_reg;
   logic                 strobe_reg;

   logic                 chanEn;
   logic                 trigEn;
   logic [2:0]           trigSel;
   logic [1:0]           waveMode;
   logic [3:0]           widthCode;
   logic [4:0]           hwNow;
   logic [4:0]           hwRise;
   logic                 trigEvent;
   logic                 doLoad;
   logic [11:0]          waveAdd;
   logic [11:0]          waveMask;
   logic [11:0]          sumValue;

   function automatic logic [11:0] widthMask(input logic [3:0] code);
      logic [11:0] m;
      m = 12'hfff;
      if (code < WIDTH_FULL) begin
         m = 12'((13'h2 << code) - 13'h1);
      end
      return m;
   endfunction

   function automatic logic [11:0] lfsrStep(input logic [11:0] v);
      logic fb;
      fb = v[11] ^ v[5] ^ v[3] ^ v[0];
      return {v[10:0], fb};
   endfunction

   function automatic logic isWrite(input logic [7:0] a);
      return wrEn && (addr == a);
   endfunction

   assign chanEn    = ctrl_reg[CHAN_EN_POS];
   assign trigEn    = ctrl_reg[TRIG_EN_POS];
   assign trigSel   = ctrl_reg[TRIG_SEL_MSB:TRIG_SEL_LSB];
   assign waveMode  = ctrl_reg[WAVE_MSB:WAVE_LSB];
   assign widthCode = ctrl_reg[WIDTH_MSB:WIDTH_LSB];
   assign waveMask  = widthMask(widthCode);
   assign hwNow     = {extLine9, timer1Trig, timer14Trig, timer2Trig,
                       timer5Trig};
   assign hwRise    = hwNow & ~hwPrev_reg;

   // Control register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= CTRL_RESET;
      end else if (isWrite(CTRL_OFFSET)) begin
         ctrl_reg <= wrData[CTRL_BITS-1:0];
      end
   end

   // R07: self-clearing trigger
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         softTrig_reg <= 1'b0;
      end else if (isWrite(SWTRIG_OFFSET) && wrData[SWTRIG_POS]) begin
         softTrig_reg <= 1'b1;
      end else begin
         softTrig_reg <= 1'b0;
      end
   end

   // R13: shared holding value
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         holding_reg <= HOLD_RESET;
      end else if (isWrite(HOLDR12_OFFSET)) begin
         // R09: right aligned
         holding_reg <= wrData[11:0];
      end else if (isWrite(HOLDL12_OFFSET)) begin
         // R10: left aligned
         holding_reg <= wrData[15:4];
      end else if (isWrite(HOLDR8_OFFSET)) begin
         // R11: upper eight bits
         holding_reg <= {wrData[7:0], 4'h0};
      end
   end

   // Edge history of hardware sources
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hwPrev_reg <= 5'h00;
      end else begin
         hwPrev_reg <= hwNow;
      end
   end

   // R04: trigger source mux
   always_comb begin
      case (trigSel)
         TSEL_TIMER5:  trigEvent = hwRise[0];
         TSEL_TIMER2:  trigEvent = hwRise[1];
         TSEL_TIMER14: trigEvent = hwRise[2];
         TSEL_TIMER1:  trigEvent = hwRise[3];
         TSEL_EXTLINE: trigEvent = hwRise[4];
         TSEL_SOFT:    trigEvent = softTrig_reg;
         // R18: reserved codes
         default:      trigEvent = 1'b0;
      endcase
   end

   // R03: R05: R14: R17: when a load happens
   assign doLoad = chanEn && (trigEn ? trigEvent : 1'b1);

   // R01: R02: wave selection
   always_comb begin
      waveAdd = 12'h000;
      if (trigEn) begin
         if (waveMode[1]) begin
            waveAdd = tri_reg;
         end else if (waveMode == WAVE_LFSR) begin
            waveAdd = lfsr_reg & waveMask;
         end
      end
   end

   assign sumValue = 12'(holding_reg + waveAdd);

   // R15: LFSR advances on each triggered load in LFSR mode
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lfsr_reg <= LFSR_SEED;
      end else if (doLoad && trigEn && waveMode == WAVE_LFSR) begin
         lfsr_reg <= lfsrStep(lfsr_reg);
      end
   end

   // R16: triangle ramps up to mask then down to zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tri_reg     <= 12'h000;
         triDown_reg <= 1'b0;
      end else if (doLoad && trigEn && waveMode[1]) begin
         if (tri_reg > waveMask) begin
            tri_reg     <= waveMask;
            triDown_reg <= 1'b1;
         end else if (!triDown_reg) begin
            if (tri_reg == waveMask) begin
               tri_reg     <= 12'(tri_reg - 12'h001);
               triDown_reg <= 1'b1;
            end else begin
               tri_reg <= 12'(tri_reg + 12'h001);
            end
         end else begin
            if (tri_reg == 12'h000) begin
               tri_reg     <= 12'h001;
               triDown_reg <= 1'b0;
            end else begin
               tri_reg <= 12'(tri_reg - 12'h001);
            end
         end
      end
   end

   // R14: output register load
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         outVal_reg <= OUTVAL_RESET;
         strobe_reg <= 1'b0;
      end else begin
         strobe_reg <= doLoad;
         if (doLoad) begin
            outVal_reg <= sumValue;
         end
      end
   end

   // R12: read data, one cycle after the read enable
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdData_reg <= 32'h0000_0000;
      end else if (rdEn) begin
         case (addr)
            CTRL_OFFSET:    rdData_reg <= {20'h00000, ctrl_reg};
            HOLDR12_OFFSET: rdData_reg <= {20'h00000, holding_reg};
            HOLDL12_OFFSET: rdData_reg <= {16'h0000, holding_reg, 4'h0};
            HOLDR8_OFFSET:  rdData_reg <= {24'h000000, holding_reg[11:4]};
            OUTVAL_OFFSET:  rdData_reg <= {20'h00000, outVal_reg};
            default:        rdData_reg <= 32'h0000_0000;
         endcase
      end else begin
         rdData_reg <= 32'h0000_0000;
      end
   end

   assign rdData         = rdData_reg;
   assign convertedValue = outVal_reg;
   assign convertStrobe  = strobe_reg;
   // R17: channel enable
   assign channelEnable  = ctrl_reg[CHAN_EN_POS];
   // R06: buffer off control
   assign bufferOff      = ctrl_reg[BUF_OFF_POS];

   AST_SWTRIG_SET: assert property (@(posedge clk) disable iff (rst) // R07
      isWrite(SWTRIG_OFFSET) && wrData[0] |=> softTrig_reg)
      else $error("software trigger not raised");

   AST_SWTRIG_CLEAR: assert property (@(posedge clk) disable iff (rst) // R07
      softTrig_reg && !(isWrite(SWTRIG_OFFSET) && wrData[0])
      |=> !softTrig_reg)
      else $error("software trigger not cleared");

   AST_HOLD_R12: assert property (@(posedge clk) disable iff (rst) // R09
      isWrite(HOLDR12_OFFSET) |=> holding_reg == $past(wrData[11:0]))
      else $error("right 12-bit load wrong");

   AST_HOLD_L12: assert property (@(posedge clk) disable iff (rst) // R10
      isWrite(HOLDL12_OFFSET) |=> holding_reg == $past(wrData[15:4]))
      else $error("left 12-bit load wrong");

   AST_HOLD_R8: assert property (@(posedge clk) disable iff (rst) // R13
      isWrite(HOLDR8_OFFSET)
      |=> holding_reg == {$past(wrData[7:0]), 4'h0})
      else $error("8-bit load wrong");

   AST_AUTO_COPY: assert property (@(posedge clk) disable iff (rst) // R14
      chanEn && !trigEn |=> convertedValue == $past(holding_reg)
      && convertStrobe)
      else $error("automatic transfer missing or wave added");

   AST_DISABLED_HOLD: assert property (@(posedge clk) disable iff (rst) // R17
      !chanEn |=> $stable(convertedValue) && !convertStrobe)
      else $error("disabled channel converted");

   AST_RESERVED_SEL: assert property (@(posedge clk) disable iff (rst) // R18
      trigEn && (trigSel == 3'h2 || trigSel == 3'h5)
      |=> $stable(convertedValue))
      else $error("reserved source triggered");

   AST_SOFT_PATH: assert property (@(posedge clk) disable iff (rst) // R04
      chanEn && trigEn && trigSel == TSEL_SOFT && waveMode == WAVE_NONE
      && isWrite(SWTRIG_OFFSET) && wrData[0] && !isWrite(CTRL_OFFSET)
      |=> ##1 convertStrobe)
      else $error("software trigger did not load");

   AST_LFSR_ADD: assert property (@(posedge clk) disable iff (rst) // R15
      doLoad && trigEn && waveMode == WAVE_LFSR
      |=> convertedValue == 12'($past(holding_reg)
          + ($past(lfsr_reg) & $past(waveMask))))
      else $error("LFSR noise sum wrong");

   AST_TRI_RANGE: assert property (@(posedge clk) disable iff (rst) // R16
      doLoad && trigEn && waveMode[1] && tri_reg <= waveMask
      && !isWrite(CTRL_OFFSET) |=> tri_reg <= waveMask)
      else $error("triangle left its range");

   AST_BUF_OFF: assert property (@(posedge clk) disable iff (rst) // R06
      isWrite(CTRL_OFFSET) |=> bufferOff == $past(wrData[1]))
      else $error("buffer off control wrong");

   AST_READ_OUT: assert property (@(posedge clk) disable iff (rst) // R12
      rdEn && addr == OUTVAL_OFFSET
      |=> rdData == {20'h00000, $past(outVal_reg)})
      else $error("output readback wrong");

   AST_LEFT_READ: assert property (@(posedge clk) disable iff (rst) // R10
      rdEn && addr == HOLDL12_OFFSET
      |=> rdData == {16'h0000, $past(holding_reg), 4'h0})
      else $error("left view readback wrong");

   AST_READ_IDLE: assert property (@(posedge clk) disable iff (rst) // R12
      !rdEn |=> rdData == 32'h0000_0000)
      else $error("read data not cleared");

   AST_CHAN_EN: assert property (@(posedge clk) disable iff (rst) // R17
      isWrite(CTRL_OFFSET) |=> channelEnable == $past(wrData[0]))
      else $error("channel enable control wrong");

   AST_TRIG_GATE: assert property (@(posedge clk) disable iff (rst) // R05
      chanEn && trigEn && !trigEvent |=> !convertStrobe)
      else $error("transfer without trigger event");

   AST_HW_EDGE: assert property (@(posedge clk) disable iff (rst) // R04
      chanEn && trigEn && trigSel == TSEL_TIMER1 && hwRise[3]
      |=> convertStrobe)
      else $error("timer edge did not load");

   COV_AUTO: cover property (@(posedge clk) disable iff (rst)
      chanEn && !trigEn ##1 convertStrobe);

   COV_SOFT: cover property (@(posedge clk) disable iff (rst)
      trigEn && trigSel == TSEL_SOFT && softTrig_reg ##1 convertStrobe);

   COV_TIMER: cover property (@(posedge clk) disable iff (rst)
      trigEn && trigSel == TSEL_TIMER14 && hwRise[2]);

   COV_TRI_TOP: cover property (@(posedge clk) disable iff (rst)
      waveMode[1] && trigEn && tri_reg == waveMask);

   COV_LFSR: cover property (@(posedge clk) disable iff (rst)
      trigEn && waveMode == WAVE_LFSR && doLoad);

endmodule // dcc_channel

// >>> verification/dcc_trig_model.sv
`timescale 1ns/100ps

// Trigger sources: each line rises one cycle after its request bit
module dcc_trig_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [4:0] fireReq,
   output logic      [4:0] trigLine
);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         trigLine <= 5'h00;
      end else begin
         trigLine <= fireReq;
      end
   end
endmodule // dcc_trig_model

// >>> verification/tb_top.sv
`timescale 1ns/100ps

module tb_top;
   import dcc_pkg::*;
   typedef struct {
      logic [7:0]  off;
      logic [31:0] wdat;
      logic [11:0] expVal;
      logic [31:0] expRd;
   } dcc_row_type;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wrData = 32'h0;
   logic        wrEn = 1'b0;
   logic        rdEn = 1'b0;
   logic [31:0] rdData;
   logic [4:0]  fireReq = 5'h00;
   logic [4:0]  trigLine;
   logic [11:0] cv;
   logic        convertStrobe;
   logic        channelEnable;
   logic        bufferOff;
   logic [31:0] rv;
   logic [2:0]  codes [5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h6};
   int          fails = 0;
   int          compares = 0;
   int          hits;
   int          triVal;
   dcc_row_type rows [3] = '{
      '{8'h08, 32'hfffff123, 12'h123, 32'h00000123},
      '{8'h0c, 32'hffffabcf, 12'habc, 32'h0000abc0},
      '{8'h10, 32'hffffff5a, 12'h5a0, 32'h0000005a}};

   always #12.5 clk = ~clk;

   dcc_trig_model src_u (.clk(clk), .rst(rst), .fireReq(fireReq),
                         .trigLine(trigLine));

   dcc_channel dut_u (
      .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn),
      .rdEn(rdEn), .rdData(rdData), .timer5Trig(trigLine[0]),
      .timer2Trig(trigLine[1]), .timer14Trig(trigLine[2]),
      .timer1Trig(trigLine[3]), .extLine9(trigLine[4]),
      .convertedValue(cv), .convertStrobe(convertStrobe),
      .channelEnable(channelEnable), .bufferOff(bufferOff));

   task automatic complete_run();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrEn <= 1'b1;
      @(posedge clk);
      wrEn <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clk);
      rdEn <= 1'b0;
      #1;
      d = rdData;
   endtask

   task automatic fire(input logic [4:0] m);
      @(posedge clk);
      fireReq <= m;
      @(posedge clk);
      fireReq <= 5'h00;
   endtask

   task automatic count_loads(input int n);
      hits = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         if (convertStrobe === 1'b1) begin
            hits++;
         end
      end
   endtask

   task automatic wait_load();
      int i;
      for (i = 0; i < 10; i++) begin
         @(posedge clk);
         #1;
         if (convertStrobe === 1'b1) begin
            break;
         end
      end
      if (i == 10) begin
         fails++;
         complete_run();
      end
   endtask

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      #1;
      check("out at reset", {20'h0, cv}, 32'h0);
      check("strobe at reset", {31'h0, convertStrobe}, 32'h0);
      check("enable at reset", {31'h0, channelEnable}, 32'h0);
      check("buffer at reset", {31'h0, bufferOff}, 32'h0);
      rd(OUTVAL_OFFSET, rv);
      check("out reg reset", rv, 32'h0);
      rd(CTRL_OFFSET, rv);
      check("ctrl reset", rv, 32'h0);
      wr(CTRL_OFFSET, 32'h1);
      foreach (rows[i]) begin
         wr(rows[i].off, rows[i].wdat);
         repeat (3) @(posedge clk);
         #1;
         check("auto value", {20'h0, cv}, {20'h0, rows[i].expVal});
         rd(rows[i].off, rv);
         check("view read", rv, rows[i].expRd);
         rd(OUTVAL_OFFSET, rv);
         check("out read", rv, {20'h0, rows[i].expVal});
      end
      wr(OUTVAL_OFFSET, 32'hfff);
      rd(OUTVAL_OFFSET, rv);
      check("out read only", rv, 32'h5a0);
      @(posedge clk);
      #1;
      check("read data idle", rdData, 32'h0);
      rd(8'h40, rv);
      check("unmapped read", rv, 32'h0);
      wr(CTRL_OFFSET, 32'h3);
      @(posedge clk);
      #1;
      check("buffer off", {31'h0, bufferOff}, 32'h1);
      check("chan enable", {31'h0, channelEnable}, 32'h1);
      wr(CTRL_OFFSET, 32'h1);
      @(posedge clk);
      #1;
      check("buffer on", {31'h0, bufferOff}, 32'h0);
      for (int k = 0; k < 5; k++) begin
         wr(CTRL_OFFSET, {26'h0, codes[k], 3'b101});
         wr(HOLDR12_OFFSET, 32'h100 + k);
         fire(5'h01 << ((k + 1) % 5));
         count_loads(4);
         check("other source", hits, 0);
         fire(5'h01 << k);
         wait_load();
         check("trig value", {20'h0, cv}, 32'h100 + k);
      end
      for (int r = 2; r < 6; r += 3) begin
         wr(CTRL_OFFSET, {26'h0, 3'(r), 3'b101});
         wr(HOLDR12_OFFSET, 32'h3ff);
         fire(5'h1f);
         wr(SWTRIG_OFFSET, 32'h1);
         count_loads(6);
         check("reserved sel", hits, 0);
      end
      wr(CTRL_OFFSET, 32'h3d);
      wr(HOLDR12_OFFSET, 32'h777);
      count_loads(3);
      check("wait soft", hits, 0);
      wr(SWTRIG_OFFSET, 32'h1);
      count_loads(6);
      check("soft once", hits, 1);
      check("soft value", {20'h0, cv}, 32'h777);
      wr(CTRL_OFFSET, 32'h3c);
      wr(SWTRIG_OFFSET, 32'h1);
      wr(CTRL_OFFSET, 32'h0);
      wr(HOLDR12_OFFSET, 32'h0aa);
      count_loads(4);
      check("disabled", {20'h0, cv}, 32'h777);
      wr(CTRL_OFFSET, 32'h37d);
      wr(HOLDR12_OFFSET, 32'h100);
      wr(SWTRIG_OFFSET, 32'h1);
      wait_load();
      check("lfsr masked", {20'h0, cv & 12'hff0}, 32'h100);
      check("lfsr value", {20'h0, cv}, 32'h100 + (LFSR_SEED & 12'h00f));
      wr(CTRL_OFFSET, 32'h1bd);
      wr(HOLDR12_OFFSET, 32'h200);
      for (int j = 0; j < 5; j++) begin
         triVal = (j <= 3) ? j : 6 - j;
         wr(SWTRIG_OFFSET, 32'h1);
         wait_load();
         check("triangle", {20'h0, cv}, 32'h200 + triVal);
      end
      wr(CTRL_OFFSET, 32'h1fd);
      wr(SWTRIG_OFFSET, 32'h1);
      wait_load();
      check("triangle 11", {20'h0, cv}, 32'h201);
      wr(CTRL_OFFSET, 32'hc1);
      wr(HOLDR12_OFFSET, 32'h345);
      repeat (3) @(posedge clk);
      #1;
      check("no wave auto", {20'h0, cv}, 32'h345);
      complete_run();
   end
endmodule // tb_top
